// >>> design/clm_link_map.svh
// Register offsets, field positions, reset values and limits of the link monitor
`ifndef CLM_LINK_MAP_SVH
`define CLM_LINK_MAP_SVH

// Register byte offsets
`define CLM_ADR_CTRL 8'h00
`define CLM_ADR_ALARM 8'h04
`define CLM_ADR_ERR 8'h08
`define CLM_ADR_ERR_CMD 8'h0c
`define CLM_ADR_FREQ 8'h10
`define CLM_ADR_STATUS 8'h14
`define CLM_ADR_CPRI_RX 8'h18
`define CLM_ADR_CPRI_TX 8'h1c
`define CLM_ADR_CORR 8'h20
`define CLM_ADR_UNCORR 8'h24
`define CLM_ADR_SYMERR 8'h28

// Control register bits
`define CLM_CTRL_FEC_EN 0
`define CLM_CTRL_STARTUP_EN 1
`define CLM_CTRL_RATE_6G 2
`define CLM_CTRL_LINE_8B10B 3

// Alarm insertion register fields
`define CLM_ALARM_SEL_LSB 0
`define CLM_ALARM_PERM 4

// Error insertion register fields
`define CLM_ERR_TYPE_LSB 0
`define CLM_ERR_MODE_LSB 4
`define CLM_ERR_BURST_LSB 8

// Error command register bit
`define CLM_ERR_CMD_INSERT 0

// Status register fields
`define CLM_ST_REMOTE_LSB 0
`define CLM_ST_LOS 5
`define CLM_ST_ALIGN_LOSS 6
`define CLM_ST_TX_LSB 8
`define CLM_ST_RX_LSB 12

// Error mode codes: off, manual, then ratios 1E-04 down to 1E-10
`define CLM_MODE_OFF 4'h0
`define CLM_MODE_MANUAL 4'h1
`define CLM_MODE_R4 4'h2
`define CLM_MODE_R10 4'h8

// Insertion period in words for ratios 1E-04 down to 1E-10
`define CLM_PERIOD_R4 34'h0_0000_2710
`define CLM_PERIOD_R5 34'h0_0001_86a0
`define CLM_PERIOD_R6 34'h0_000f_4240
`define CLM_PERIOD_R7 34'h0_0098_9680
`define CLM_PERIOD_R8 34'h0_05f5_e100
`define CLM_PERIOD_R9 34'h0_3b9a_ca00
`define CLM_PERIOD_R10 34'h2_540b_e400

// Reset values
`define CLM_RST_CTRL 4'h0
`define CLM_RST_BURST 16'h0001
`define CLM_RST_FREQ 16'h0000

// Code violations per hyperframe that mean loss of signal
`define CLM_LOS_CV_LIMIT 5'h10

`endif

// >>> design/clm_link_pkg.sv
// Types shared by the link monitor and its surroundings
package clm_link_pkg;

  // Transmit link states
  typedef enum logic [2:0] {
    CLM_TX_OFF = 3'b000,
    CLM_TX_IDLE = 3'b001,
    CLM_TX_IDLE_REQ = 3'b010,
    CLM_TX_IDLE_ACK = 3'b011,
    CLM_TX_FRAME = 3'b100
  } clm_tx_state_type;

  // Receive link states
  typedef enum logic [2:0] {
    CLM_RX_UNSYNC = 3'b000,
    CLM_RX_WAIT_SEED = 3'b001,
    CLM_RX_WAIT_ACK = 3'b010,
    CLM_RX_WAIT_IDLES = 3'b011,
    CLM_RX_WAIT_FSYNC = 3'b100,
    CLM_RX_FRAME_SYNC = 3'b101
  } clm_rx_state_type;

  // Link parameters of one direction
  typedef struct packed {
    logic [7:0] version;
    logic [2:0] hdlc_rate;
    logic [5:0] pointer;
    logic [2:0] link_state;
    logic port_role;
  } clm_cpri_par_type;

  // One-cycle events and levels from the receive datapath
  typedef struct packed {
    logic hf_start;
    logic code_viol;
    logic z130_valid;
    logic [4:0] z130_bits;
    logic fec_align_lost;
    logic fec_corr;
    logic fec_uncorr;
    logic fec_sym_err;
    logic tx_enable;
    logic sync_ok;
    logic seed_seen;
    logic ack_seen;
    logic idles_seen;
    logic frame_sync;
    logic sync_lost;
  } clm_link_in_type;

endpackage

// >>> design/clm_link_monitor.sv
// Link status monitor and stimulus inserter for a serial radio link test port
//
// Operation
// - Remote indicator follows received inband bit value
// - Separate LOS, LOF, RAI, SDI, reset indications
// - FEC enabled: align loss and three counters
// - Transmit states; idle split only at 6144.0
// - Receive states; seed and ack only 6144.0
// - Report link parameters; state, role need start-up
// - Alarm insertion off or permanent
// - Manual mode inserts burst per command
// - Rate mode 1E-04 to 1E-10, off stops
// - Signed ppm offset applied to transmit rate
// - Sixteen code violations per hyperframe mean LOS
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "clm_link_map.svh"

module clm_link_monitor
  import clm_link_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter int BURST_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Receive datapath, same clock
  input wire clm_link_in_type link_in,
  input wire clm_cpri_par_type cpri_rx_par,
  input wire clm_cpri_par_type cpri_tx_par,
  // Transmit stimulus
  output logic [4:0] tx_alarm,
  output logic tx_err_strobe,
  output logic [2:0] tx_err_type,
  output logic [15:0] tx_freq_ofs_ppm,
  // Status
  output logic [4:0] remote_ind,
  output logic link_los,
  output logic fec_frame_align_loss,
  output clm_tx_state_type obsai_tx_state,
  output clm_rx_state_type obsai_rx_state
);

  // Refuse widths the registers cannot hold
  if (CNT_W < 8 || CNT_W > 32 || BURST_W < 1 || BURST_W > 16) begin : g_bad_width
    $error("clm_link_monitor: unsupported counter or burst width");
  end

  // Whole state of the block
  typedef struct packed {
    logic fec_en;
    logic startup_en;
    logic rate_6g;
    logic line_8b10b;
    logic [2:0] alarm_sel;
    logic alarm_perm;
    logic [2:0] err_type;
    logic [3:0] err_mode;
    logic [BURST_W-1:0] burst_len;
    logic [15:0] freq_ofs;
    logic [4:0] remote;
    logic los;
    logic align_loss;
    logic [4:0] cv_cnt;
    logic [CNT_W-1:0] corr_cnt;
    logic [CNT_W-1:0] uncorr_cnt;
    logic [CNT_W-1:0] sym_cnt;
    logic [BURST_W-1:0] burst_left;
    logic [33:0] rate_cnt;
    clm_tx_state_type tx_st;
    clm_rx_state_type rx_st;
    logic err_strobe;
    logic [4:0] alarm_out;
    logic [31:0] rdata;
  } clm_state_type;

  clm_state_type state;
  clm_state_type next_state;

  // Insertion period in words for each ratio code
  function automatic logic [33:0] clm_rate_period(input logic [3:0] mode);
    logic [33:0] p;
    p = 34'h0;
    case (mode)
      4'h2: p = `CLM_PERIOD_R4;
      4'h3: p = `CLM_PERIOD_R5;
      4'h4: p = `CLM_PERIOD_R6;
      4'h5: p = `CLM_PERIOD_R7;
      4'h6: p = `CLM_PERIOD_R8;
      4'h7: p = `CLM_PERIOD_R9;
      4'h8: p = `CLM_PERIOD_R10;
      default: p = 34'h0;
    endcase
    return p;
  endfunction

  // Saturating event counter, shared by the three FEC counts
  function automatic logic [CNT_W-1:0] clm_count(input logic [CNT_W-1:0] c, input logic ev);
    logic [CNT_W-1:0] r;
    r = c;
    if (ev && (c != {CNT_W{1'b1}})) begin
      r = c + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    return r;
  endfunction

  // Link parameters as one register word
  function automatic logic [31:0] clm_par_word(input clm_cpri_par_type p, input logic show_link);
    logic [31:0] w;
    w = 32'h0;
    w[7:0] = p.version;
    w[10:8] = p.hdlc_rate;
    w[17:12] = p.pointer;
    if (show_link) begin
      w[22:20] = p.link_state;
      w[24] = p.port_role;
    end
    return w;
  endfunction

  // Next-state logic
  always_comb begin
    logic insert_cmd;
    logic err_wr;
    logic [33:0] period;
    next_state = state;
    insert_cmd = 1'b0;
    err_wr = 1'b0;
    period = clm_rate_period(state.err_mode);
    next_state.err_strobe = 1'b0;
    next_state.rdata = 32'h0;

    // Register writes steer configuration
    if (reg_wr) begin
      case (reg_addr)
        `CLM_ADR_CTRL: begin
          next_state.fec_en = reg_wdata[`CLM_CTRL_FEC_EN];
          next_state.startup_en = reg_wdata[`CLM_CTRL_STARTUP_EN];
          next_state.rate_6g = reg_wdata[`CLM_CTRL_RATE_6G];
          next_state.line_8b10b = reg_wdata[`CLM_CTRL_LINE_8B10B];
        end
        `CLM_ADR_ALARM: begin
          next_state.alarm_sel = reg_wdata[`CLM_ALARM_SEL_LSB +: 3];
          next_state.alarm_perm = reg_wdata[`CLM_ALARM_PERM];
        end
        `CLM_ADR_ERR: begin
          next_state.err_type = reg_wdata[`CLM_ERR_TYPE_LSB +: 3];
          next_state.err_mode = reg_wdata[`CLM_ERR_MODE_LSB +: 4];
          next_state.burst_len = reg_wdata[`CLM_ERR_BURST_LSB +: BURST_W];
          // Any mode change abandons a burst or ratio in progress
          err_wr = 1'b1;
          next_state.burst_left = '0;
          next_state.rate_cnt = 34'h0;
        end
        `CLM_ADR_ERR_CMD: insert_cmd = reg_wdata[`CLM_ERR_CMD_INSERT];
        `CLM_ADR_FREQ: next_state.freq_ofs = reg_wdata[15:0];
        default: ;
      endcase
    end

    // Read data, valid the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `CLM_ADR_CTRL: begin
          next_state.rdata[`CLM_CTRL_FEC_EN] = state.fec_en;
          next_state.rdata[`CLM_CTRL_STARTUP_EN] = state.startup_en;
          next_state.rdata[`CLM_CTRL_RATE_6G] = state.rate_6g;
          next_state.rdata[`CLM_CTRL_LINE_8B10B] = state.line_8b10b;
        end
        `CLM_ADR_ALARM: begin
          next_state.rdata[`CLM_ALARM_SEL_LSB +: 3] = state.alarm_sel;
          next_state.rdata[`CLM_ALARM_PERM] = state.alarm_perm;
        end
        `CLM_ADR_ERR: begin
          next_state.rdata[`CLM_ERR_TYPE_LSB +: 3] = state.err_type;
          next_state.rdata[`CLM_ERR_MODE_LSB +: 4] = state.err_mode;
          next_state.rdata[`CLM_ERR_BURST_LSB +: BURST_W] = state.burst_len;
        end
        `CLM_ADR_FREQ: next_state.rdata[15:0] = state.freq_ofs;
        `CLM_ADR_STATUS: begin
          next_state.rdata[`CLM_ST_REMOTE_LSB +: 5] = state.remote;
          next_state.rdata[`CLM_ST_LOS] = state.los;
          next_state.rdata[`CLM_ST_ALIGN_LOSS] = state.align_loss;
          next_state.rdata[`CLM_ST_TX_LSB +: 3] = state.tx_st;
          next_state.rdata[`CLM_ST_RX_LSB +: 3] = state.rx_st;
        end
        `CLM_ADR_CPRI_RX: next_state.rdata = clm_par_word(cpri_rx_par, state.startup_en);
        `CLM_ADR_CPRI_TX: next_state.rdata = clm_par_word(cpri_tx_par, state.startup_en);
        `CLM_ADR_CORR: next_state.rdata[CNT_W-1:0] = state.corr_cnt;
        `CLM_ADR_UNCORR: next_state.rdata[CNT_W-1:0] = state.uncorr_cnt;
        `CLM_ADR_SYMERR: next_state.rdata[CNT_W-1:0] = state.sym_cnt;
        default: next_state.rdata = 32'h0;
      endcase
    end

    if (link_in.z130_valid) begin
      next_state.remote = link_in.z130_bits;
    end

    if (!state.line_8b10b) begin
      next_state.cv_cnt = 5'h0;
      next_state.los = 1'b0;
    end else if (link_in.hf_start) begin
      // Count of the closing hyperframe decides, a violation on the boundary opens the next
      next_state.los = (state.cv_cnt >= `CLM_LOS_CV_LIMIT);
      next_state.cv_cnt = {4'h0, link_in.code_viol};
    end else if (link_in.code_viol && (state.cv_cnt != `CLM_LOS_CV_LIMIT)) begin
      next_state.cv_cnt = state.cv_cnt + 5'h1;
    end

    if (state.fec_en) begin
      next_state.align_loss = link_in.fec_align_lost;
      next_state.corr_cnt = clm_count(state.corr_cnt, link_in.fec_corr);
      next_state.uncorr_cnt = clm_count(state.uncorr_cnt, link_in.fec_uncorr);
      next_state.sym_cnt = clm_count(state.sym_cnt, link_in.fec_sym_err);
    end else begin
      next_state.align_loss = 1'b0;
      next_state.corr_cnt = '0;
      next_state.uncorr_cnt = '0;
      next_state.sym_cnt = '0;
    end

    if (link_in.sync_lost) begin
      next_state.rx_st = CLM_RX_UNSYNC;
    end else begin
      unique case (state.rx_st)
        CLM_RX_UNSYNC: begin
          if (link_in.sync_ok) begin
            next_state.rx_st = state.rate_6g ? CLM_RX_WAIT_SEED : CLM_RX_WAIT_IDLES;
          end
        end
        CLM_RX_WAIT_SEED: begin
          if (link_in.seed_seen) begin
            next_state.rx_st = CLM_RX_WAIT_ACK;
          end
        end
        CLM_RX_WAIT_ACK: begin
          if (link_in.ack_seen) begin
            next_state.rx_st = CLM_RX_WAIT_IDLES;
          end
        end
        CLM_RX_WAIT_IDLES: begin
          if (link_in.idles_seen) begin
            next_state.rx_st = CLM_RX_WAIT_FSYNC;
          end
        end
        CLM_RX_WAIT_FSYNC: begin
          if (link_in.frame_sync) begin
            next_state.rx_st = CLM_RX_FRAME_SYNC;
          end
        end
        CLM_RX_FRAME_SYNC: ;
        default: next_state.rx_st = CLM_RX_UNSYNC;
      endcase
    end

    if (!link_in.tx_enable) begin
      next_state.tx_st = CLM_TX_OFF;
    end else begin
      unique case (state.tx_st)
        CLM_TX_OFF: next_state.tx_st = state.rate_6g ? CLM_TX_IDLE_REQ : CLM_TX_IDLE;
        CLM_TX_IDLE: begin
          if (state.rx_st == CLM_RX_FRAME_SYNC) begin
            next_state.tx_st = CLM_TX_FRAME;
          end
        end
        CLM_TX_IDLE_REQ: begin
          if (link_in.ack_seen) begin
            next_state.tx_st = CLM_TX_IDLE_ACK;
          end
        end
        CLM_TX_IDLE_ACK: begin
          if (state.rx_st == CLM_RX_FRAME_SYNC) begin
            next_state.tx_st = CLM_TX_FRAME;
          end
        end
        CLM_TX_FRAME: begin
          // Losing receive sync drops the transmitter back to idle signalling
          if (state.rx_st != CLM_RX_FRAME_SYNC) begin
            next_state.tx_st = state.rate_6g ? CLM_TX_IDLE_REQ : CLM_TX_IDLE;
          end
        end
        default: next_state.tx_st = CLM_TX_OFF;
      endcase
    end

    next_state.alarm_out = 5'h0;
    if (state.alarm_perm && (state.alarm_sel < 3'h5)) begin
      next_state.alarm_out[state.alarm_sel] = 1'b1;
    end

    if ((state.err_mode == `CLM_MODE_MANUAL) && !err_wr) begin
      if (state.burst_left != '0) begin
        next_state.err_strobe = 1'b1;
        next_state.burst_left = state.burst_left - {{(BURST_W-1){1'b0}}, 1'b1};
      end
      // A command during a burst restarts it rather than queueing
      if (insert_cmd) begin
        next_state.burst_left = state.burst_len;
      end
    end

    if (!err_wr && (state.err_mode >= `CLM_MODE_R4) && (state.err_mode <= `CLM_MODE_R10)) begin
      if (state.rate_cnt >= period - 34'h1) begin
        next_state.rate_cnt = 34'h0;
        next_state.err_strobe = 1'b1;
      end else begin
        next_state.rate_cnt = state.rate_cnt + 34'h1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= '{tx_st: CLM_TX_OFF, rx_st: CLM_RX_UNSYNC, err_mode: `CLM_MODE_OFF,
        burst_len: BURST_W'(`CLM_RST_BURST), freq_ofs: `CLM_RST_FREQ, default: '0};
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = state.rdata;
  assign tx_alarm = state.alarm_out;
  assign tx_err_strobe = state.err_strobe;
  assign tx_err_type = state.err_type;
  assign tx_freq_ofs_ppm = state.freq_ofs;
  assign remote_ind = state.remote;
  assign link_los = state.los;
  assign fec_frame_align_loss = state.align_loss;
  assign obsai_tx_state = state.tx_st;
  assign obsai_rx_state = state.rx_st;

endmodule

// >>> sim/clm_link_far.sv
// Far-end radio equipment model driving the receive-side events of the monitor
`timescale 1ns/100ps

module clm_link_far
  import clm_link_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Events and levels toward the monitor
  output clm_link_in_type link_in
);
  clm_link_in_type lvl;

  // Quiet link at time zero
  initial begin
    lvl = '0;
    link_in = '0;
  end

  // One event for one cycle, or a level change held afterwards
  task automatic go(input int k);
    clm_link_in_type p;
    p = lvl;
    case (k)
      0: p.sync_ok = 1'b1;
      1: p.seed_seen = 1'b1;
      2: p.ack_seen = 1'b1;
      3: p.idles_seen = 1'b1;
      4: p.frame_sync = 1'b1;
      5: p.sync_lost = 1'b1;
      6: p.fec_corr = 1'b1;
      7: p.fec_uncorr = 1'b1;
      8: p.fec_sym_err = 1'b1;
      9: p.hf_start = 1'b1;
      10: p.code_viol = 1'b1;
      11: lvl.tx_enable = 1'b1;
      12: lvl.tx_enable = 1'b0;
      13: lvl.fec_align_lost = 1'b1;
      14: lvl.fec_align_lost = 1'b0;
      default: ;
    endcase
    if (k > 10) p = lvl;
    @(posedge sys_clk);
    link_in <= p;
    @(posedge sys_clk);
    link_in <= lvl;
  endtask

  // Inband bits are inverted after their valid cycle so a stale copy never matches
  task automatic z130(input logic [4:0] b);
    clm_link_in_type p;
    p = lvl;
    p.z130_valid = 1'b1;
    p.z130_bits = b;
    lvl.z130_bits = ~b;
    @(posedge sys_clk);
    link_in <= p;
    @(posedge sys_clk);
    link_in <= lvl;
  endtask
endmodule

// >>> sim/clm_link_monitor_chk.sv
// Concurrent checks on the link monitor ports
`timescale 1ns/100ps
`include "clm_link_map.svh"

module clm_link_monitor_chk
  import clm_link_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Receive datapath
  input wire clm_link_in_type link_in,
  // Outputs under watch
  input wire logic [4:0] tx_alarm,
  input wire logic tx_err_strobe,
  input wire logic [4:0] remote_ind,
  input wire logic link_los,
  input wire logic fec_frame_align_loss,
  input wire clm_tx_state_type obsai_tx_state,
  input wire clm_rx_state_type obsai_rx_state
);
  logic fec_q, r6_q, l8_q, mode_q;
  logic [4:0] cv, alm_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Shadow of the settings the checks depend on
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      {fec_q, r6_q, l8_q, mode_q, alm_q} <= '0;
    end else if (reg_wr && reg_addr == `CLM_ADR_CTRL) begin
      {l8_q, r6_q, fec_q} <= {reg_wdata[3], reg_wdata[2], reg_wdata[0]};
    end else if (reg_wr && reg_addr == `CLM_ADR_ERR) begin
      mode_q <= reg_wdata[7:4] >= 4'h1 && reg_wdata[7:4] <= 4'h8;
    end else if (reg_wr && reg_addr == `CLM_ADR_ALARM) begin
      alm_q <= reg_wdata[4] ? 5'h01 << reg_wdata[2:0] : 5'h00;
    end
  end

  // Violations since the last hyperframe start; saturates so it never wraps below the limit
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cv <= 5'h00;
    end else if (link_in.hf_start) begin
      cv <= {4'h0, link_in.code_viol};
    end else if (link_in.code_viol && cv != 5'h1f) begin
      cv <= cv + 5'h01;
    end
  end

  sequence s_alarm_wr;
    reg_wr && reg_addr == `CLM_ADR_ALARM;
  endsequence

  chk_remote_copy: assert property (link_in.z130_valid |=> remote_ind == $past(link_in.z130_bits))
    else $error("remote indication differs from inband bits");
  chk_align_track: assert property (fec_q && $past(fec_q) && $past(fec_q, 2) |->
    fec_frame_align_loss == $past(link_in.fec_align_lost)) else $error("align loss does not follow input");
  chk_tx_idle_split: assert property (obsai_tx_state inside {CLM_TX_IDLE, CLM_TX_IDLE_REQ, CLM_TX_IDLE_ACK} |->
    (obsai_tx_state != CLM_TX_IDLE) == r6_q) else $error("transmit idle state wrong for line rate");
  chk_rx_seed_rate: assert property (obsai_rx_state inside {CLM_RX_WAIT_SEED, CLM_RX_WAIT_ACK} |-> r6_q)
    else $error("seed or ack state at wrong line rate");
  chk_rx_sync_lost: assert property (link_in.sync_lost |=> obsai_rx_state == CLM_RX_UNSYNC)
    else $error("receive state kept after sync loss");
  chk_alarm_set: assert property (s_alarm_wr |-> ##2 tx_alarm == alm_q)
    else $error("inserted alarm differs from setting");
  chk_err_quiet: assert property (tx_err_strobe |-> mode_q || $past(mode_q) || $past(mode_q, 2) ||
    $past(mode_q, 3)) else $error("error inserted while insertion off");
  chk_los_limit: assert property (link_in.hf_start && l8_q |=>
    link_los == ($past(cv) >= `CLM_LOS_CV_LIMIT)) else $error("loss of signal wrong at hyperframe");
endmodule

bind clm_link_monitor clm_link_monitor_chk clm_link_monitor_chk_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .link_in(link_in), .tx_alarm(tx_alarm), .tx_err_strobe(tx_err_strobe), .remote_ind(remote_ind),
  .link_los(link_los), .fec_frame_align_loss(fec_frame_align_loss), .obsai_tx_state(obsai_tx_state),
  .obsai_rx_state(obsai_rx_state)
);

// >>> sim/tb.sv
// Self-checking bench for the link monitor
`timescale 1ns/100ps
`include "clm_link_map.svh"

module tb
  import clm_link_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  clm_link_in_type link_in;
  clm_cpri_par_type rx_par = '{8'h21, 3'h5, 6'h2a, 3'h6, 1'b1};
  clm_cpri_par_type tx_par = '{8'h03, 3'h1, 6'h05, 3'h2, 1'b0};
  logic [4:0] tx_alarm, remote_ind;
  logic tx_err_strobe, link_los, align_loss;
  logic [2:0] tx_err_type;
  logic [15:0] tx_freq_ofs_ppm;
  clm_tx_state_type tx_st;
  clm_rx_state_type rx_st;
  int err_total = 0;
  int checks = 0;
  int n;

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  clm_link_monitor clm_link_monitor_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_in(link_in),
    .cpri_rx_par(rx_par), .cpri_tx_par(tx_par), .tx_alarm(tx_alarm), .tx_err_strobe(tx_err_strobe),
    .tx_err_type(tx_err_type), .tx_freq_ofs_ppm(tx_freq_ofs_ppm), .remote_ind(remote_ind),
    .link_los(link_los), .fec_frame_align_loss(align_loss), .obsai_tx_state(tx_st), .obsai_rx_state(rx_st));
  clm_link_far clm_link_far_inst (.sys_clk(sys_clk), .link_in(link_in));

  // Compare, count and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // Register port master: one-cycle strobes, read data sampled in the cycle after
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk(reg_rdata, exp);
  endtask

  task automatic go(input int k);
    clm_link_far_inst.go(k);
  endtask

  // Hyperframe start followed by a number of code violations
  task automatic hf(input int c);
    go(9);
    repeat (c) go(10);
  endtask

  // Count inserted errors over a window
  task automatic cnt(input int k);
    n = 0;
    repeat (k) begin
      @(posedge sys_clk);
      // An unknown strobe counts as an error so it cannot pass a quiet check
      n += (tx_err_strobe === 1'b0) ? 0 : 1;
    end
  endtask

  // One link event, then both state machines compared
  task automatic step(input int k, input logic [2:0] rx, input logic [2:0] tx);
    go(k);
    tick(2);
    chk(32'(rx_st), 32'(rx));
    chk(32'(tx_st), 32'(tx));
  endtask

  // Hang guard: a run this long counts as a mismatch
  initial begin
    tick(80000);
    err_total++;
    stop_test();
  end

  // Main sequence
  initial begin
    tick(6);
    reset_n <= 1'b1;
    rd(`CLM_ADR_ALARM, 32'h0);
    rd(`CLM_ADR_ERR, 32'h100);
    rd(`CLM_ADR_FREQ, 32'h0);
    chk(32'({tx_alarm, tx_err_strobe, tx_freq_ofs_ppm}), 32'h0);
    for (int i = 0; i < 5; i++) begin
      clm_link_far_inst.z130(5'h01 << i);
      tick(1);
      chk(32'(remote_ind), 32'h1 << i);
    end
    clm_link_far_inst.z130(5'h00);
    rd(`CLM_ADR_STATUS, 32'h0);
    // Plain line rate, then the seed and ack path at the high rate
    step(11, 0, 1);
    step(0, 3, 1);
    step(3, 4, 1);
    step(4, 5, 4);
    rd(`CLM_ADR_STATUS, 32'h5400);
    step(12, 5, 0);
    step(5, 0, 0);
    wr(`CLM_ADR_CTRL, 32'h4);
    step(11, 0, 2);
    step(0, 1, 2);
    step(1, 2, 2);
    step(2, 3, 3);
    step(3, 4, 3);
    step(4, 5, 4);
    step(12, 5, 0);
    step(5, 0, 0);
    // FEC indications and code violation limit
    wr(`CLM_ADR_CTRL, 32'h9);
    go(6);
    go(6);
    go(7);
    go(8);
    go(13);
    tick(1);
    chk(32'(align_loss), 32'h1);
    rd(`CLM_ADR_CORR, 32'h2);
    rd(`CLM_ADR_UNCORR, 32'h1);
    rd(`CLM_ADR_SYMERR, 32'h1);
    hf(16);
    hf(15);
    tick(1);
    chk(32'(link_los), 32'h1);
    hf(0);
    tick(1);
    chk(32'(link_los), 32'h0);
    wr(`CLM_ADR_CTRL, 32'h2);
    rd(`CLM_ADR_CORR, 32'h0);
    chk(32'(align_loss), 32'h0);
    rd(`CLM_ADR_CPRI_RX, 32'h0162a521);
    rd(`CLM_ADR_CPRI_TX, 32'h00205103);
    wr(`CLM_ADR_CTRL, 32'h0);
    rd(`CLM_ADR_CPRI_RX, 32'h0002a521);
    go(14);
    // Alarms on every selection, then off
    for (int i = 0; i < 5; i++) begin
      wr(`CLM_ADR_ALARM, 32'h10 | i);
      tick(2);
      chk(32'(tx_alarm), 32'h1 << i);
    end
    wr(`CLM_ADR_ALARM, 32'h4);
    tick(2);
    chk(32'(tx_alarm), 32'h0);
    // Manual burst of five, then the error type on the output
    wr(`CLM_ADR_ERR, 32'h513);
    wr(`CLM_ADR_ERR_CMD, 32'h1);
    cnt(20);
    chk(n, 5);
    chk(32'(tx_err_type), 32'h3);
    // A mode write mid-burst drops the rest of the burst
    wr(`CLM_ADR_ERR_CMD, 32'h1);
    wr(`CLM_ADR_ERR, 32'h503);
    wr(`CLM_ADR_ERR, 32'h513);
    cnt(20);
    chk(n, 0);
    wr(`CLM_ADR_ERR, 32'h503);
    wr(`CLM_ADR_ERR_CMD, 32'h1);
    cnt(20);
    chk(n, 0);
    // Ratio 1E-04 gives one error per ten thousand words; lower ratios stay quiet this short
    wr(`CLM_ADR_ERR, 32'h123);
    cnt(25000);
    chk(n, 2);
    for (int m = 3; m < 10; m++) begin
      wr(`CLM_ADR_ERR, 32'h103 | (m << 4));
      cnt(200);
      chk(n, 0);
    end
    wr(`CLM_ADR_ERR, 32'h103);
    cnt(12000);
    chk(n, 0);
    // Negative and positive offsets
    wr(`CLM_ADR_FREQ, 32'hfffb);
    tick(2);
    chk(32'(tx_freq_ofs_ppm), 32'hfffb);
    wr(`CLM_ADR_FREQ, 32'h7);
    tick(2);
    chk(32'(tx_freq_ofs_ppm), 32'h7);
    stop_test();
  end
endmodule
